// ==== rtl/battery_prime_reset_sequencer.sv ====
// battery and prime power reset sequencer with power-fail lockout
`timescale 1ns/1ps
`include "reset_seq_map.svh"
module battery_prime_reset_sequencer
	import reset_seq_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic battery_rst_in_n,
	input wire logic power_fail_in_n,
	input wire logic core_supply_ok,
	input wire logic rtc_osc_out,
	input wire logic peripheral_clock,
	input wire logic auxiliary_clock,
	input wire logic ext_sys_rst_line_in,
	input wire logic watchdog_expired,
	input wire logic lockout_enable_write,
	input wire logic settings_write,
	input wire logic [15:0] settings_wdata,
	input wire logic dram_refresh_busy,
	output logic battery_domain_rst_n,
	output logic prime_rst_n,
	output logic internal_core_rst_n,
	output logic ext_sys_rst_line_out,
	output logic ext_sys_rst_line_oe,
	output logic power_fail_interrupt,
	output logic cpu_lockout,
	output logic battery_refresh_mode,
	output logic sram_cs_oe,
	output logic dram_strobe_oe,
	output logic [15:0] battery_settings_register
);

	pin_in_t raw_pins;
	pin_in_t pins;
	pin_in_t pins_d;
	logic rtc_rise;
	logic periph_rise;
	logic aux_rise;
	logic pf_fall;
	logic reset_tick;
	logic prime_drop;
	logic third_reset;
	logic dram_backup_on;
	logic lock_event;
	logic [11:0] div_cnt;
	logic [11:0] next_div_cnt;
	seq_state_t state;
	seq_state_t next_state;
	logic [3:0] cnt;
	logic [3:0] next_cnt;
	logic [3:0] tmo;
	logic [3:0] next_tmo;
	logic [15:0] settings;
	logic [15:0] next_settings;
	ctrl_out_t ctrl;
	ctrl_out_t next_ctrl;

	// every pin input crosses two flops before any logic looks at it
	assign raw_pins = {battery_rst_in_n, power_fail_in_n, core_supply_ok,
		rtc_osc_out, peripheral_clock, auxiliary_clock,
		ext_sys_rst_line_in}; // [R23]

	pin_sync2 #(
		.WIDTH($bits(pin_in_t))
	) u_pin_sync (
		.clk(sys_clk),
		.rst_n(rst_n),
		.d(raw_pins),
		.q(pins)
	);

	// delayed copy for edge detection, taken from the second stage
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pins_d <= '0;
		end else begin
			pins_d <= pins;
		end
	end

	// edge strobes on the retimed pins
	assign rtc_rise = pins.rtc_osc & ~pins_d.rtc_osc;
	assign periph_rise = pins.periph_clk & ~pins_d.periph_clk;
	assign aux_rise = pins.aux_clk & ~pins_d.aux_clk;
	assign pf_fall = ~pins.power_fail_n & pins_d.power_fail_n;

	// reset clock: falling edge when the rtc edge count wraps
	assign reset_tick = rtc_rise && (div_cnt == `RESET_CLK_DIV_MAX); // [R8]

	always_comb begin
		next_div_cnt = div_cnt;
		if (rtc_rise) begin
			next_div_cnt = div_cnt + 12'h001; // [R8]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt <= 12'h000;
		end else begin
			div_cnt <= next_div_cnt;
		end
	end

	// prime power gone, or power-fail warning active
	assign prime_drop = !pins.power_fail_n || !pins.core_ok; // [R6]
	// watchdog or someone else pulling the shared line low
	assign third_reset = watchdog_expired || !pins.sys_line_n; // [R2]
	assign dram_backup_on =
		settings[`DRAM_BACKUP_HI:`DRAM_BACKUP_LO] != `DRAM_BACKUP_OFF;

	// power-up and power-fail sequencing
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_tmo = tmo;
		lock_event = 1'b0;
		if (!pins.battery_rst_n) begin
			next_state = ST_BATT_RST; // [R3]
			next_cnt = 4'h0;
		end else begin
			case (state)
				ST_BATT_RST: begin
					next_state = ST_OFF;
				end
				ST_OFF: begin
					if (!prime_drop) begin
						next_state = ST_FIRST_POWERUP_DELAY; // [R7]
						next_cnt = 4'h0;
					end
				end
				ST_FIRST_POWERUP_DELAY: begin
					// counting falls gives one or two periods by phase
					if (prime_drop) begin
						next_state = ST_OFF;
					end else if (reset_tick) begin
						if (cnt[2:0] == `FIRST_POWERUP_DELAY_FALLS - 3'h1) begin
							next_state = ST_SECOND_POWERUP_DELAY; // [R7]
							next_cnt = 4'h0;
						end else begin
							next_cnt = cnt + 4'h1;
						end
					end
				end
				ST_SECOND_POWERUP_DELAY: begin
					if (prime_drop) begin
						next_state = ST_OFF;
					end else if (periph_rise) begin
						if (cnt == `SECOND_POWERUP_DELAY_PERIODS - 4'h1) begin
							next_state = ST_LINE_SYNC; // [R9]
							next_cnt = 4'h0;
						end else begin
							next_cnt = cnt + 4'h1;
						end
					end
				end
				ST_LINE_SYNC: begin
					// line release is retimed to the auxiliary clock
					if (prime_drop) begin
						next_state = ST_OFF;
					end else if (aux_rise) begin
						next_state = ST_CORE_WAIT; // [R9] [R10]
						next_cnt = 4'h0;
					end
				end
				ST_CORE_WAIT: begin
					if (prime_drop) begin
						next_state = ST_OFF;
					end else if (periph_rise) begin
						if (cnt == `CORE_WAIT_PERIODS - 4'h1) begin
							next_state = ST_UNLOCK; // [R11]
						end else begin
							next_cnt = cnt + 4'h1;
						end
					end
				end
				ST_UNLOCK: begin
					if (prime_drop) begin
						next_state = ST_OFF;
					end else if (rtc_rise) begin
						next_state = ST_RUN; // [R12]
					end
				end
				ST_RUN: begin
					if (pf_fall && pins.core_ok) begin
						next_state = ST_ARM; // [R13]
						next_tmo = 4'h0;
					end else if (!pins.core_ok) begin
						next_state = ST_OFF;
					end else if (third_reset) begin
						// battery side untouched, only prime logic restarts
						next_state = ST_SECOND_POWERUP_DELAY; // [R2] [R22]
						next_cnt = 4'h0;
					end
				end
				ST_ARM: begin
					// software normally arms; the time-out is the backstop
					if (lockout_enable_write ||
						tmo == `LOCK_TIMEOUT_TICKS) begin // [R17]
						lock_event = 1'b1; // [R19]
						next_tmo = `LOCK_TIMEOUT_TICKS;
						if (!dram_backup_on || !dram_refresh_busy) begin
							next_state = ST_LOCKOUT; // [R15]
						end
					end else if (reset_tick) begin
						next_tmo = tmo + 4'h1; // [R17]
					end
				end
				ST_LOCKOUT: begin
					// only a supply loss or a low battery reset input leaves lockout
					if (!pins.core_ok) begin
						next_state = ST_OFF; // [R16]
					end
				end
				default: begin
					next_state = ST_BATT_RST;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_BATT_RST;
			cnt <= 4'h0;
			tmo <= 4'h0;
		end else begin
			state <= next_state;
			cnt <= next_cnt;
			tmo <= next_tmo;
		end
	end

	// battery settings register: writes blocked while locked out
	always_comb begin
		next_settings = settings;
		if (!pins.battery_rst_n) begin
			next_settings = `SETTINGS_RST_VAL; // [R4]
		end else if (settings_write && !ctrl.lockout) begin
			next_settings = settings_wdata & `SETTINGS_USED_MASK;
			// flags clear only on a written one
			next_settings[`BATT_FLAG_BIT] = settings[`BATT_FLAG_BIT] &
				~settings_wdata[`BATT_FLAG_BIT]; // [R20]
			next_settings[`LOCK_FLAG_BIT] = settings[`LOCK_FLAG_BIT] &
				~settings_wdata[`LOCK_FLAG_BIT]; // [R20]
		end
		// a set in the same cycle as a clear wins
		if (!pins.battery_rst_n) begin
			next_settings[`BATT_FLAG_BIT] = 1'b1; // [R18]
		end
		if (lock_event) begin
			next_settings[`LOCK_FLAG_BIT] = 1'b1; // [R19]
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			settings <= `SETTINGS_RST_VAL;
		end else begin
			settings <= next_settings;
		end
	end

	// output decode from the coming state, so outputs track it exactly
	always_comb begin
		next_ctrl = ctrl;
		next_ctrl.batt_rst_n = !(next_state inside
			{ST_BATT_RST, ST_OFF, ST_FIRST_POWERUP_DELAY, ST_LOCKOUT}); // [R1] [R3] [R16]
		next_ctrl.prime_rst_n = !(next_state inside
			{ST_BATT_RST, ST_OFF, ST_FIRST_POWERUP_DELAY, ST_LOCKOUT}); // [R1] [R6]
		next_ctrl.core_rst_n = next_state inside
			{ST_UNLOCK, ST_RUN, ST_ARM}; // [R11]
		next_ctrl.line_oe = !(next_state inside
			{ST_CORE_WAIT, ST_UNLOCK, ST_RUN, ST_ARM}); // [R10]
		next_ctrl.irq = next_state == ST_ARM; // [R13]
		next_ctrl.lockout = !(next_state inside
			{ST_RUN, ST_ARM}); // [R4] [R12]
		// refresh mode lasts from lockout until prime logic is back
		if (next_state inside {ST_BATT_RST, ST_RUN}) begin
			next_ctrl.refresh_mode = 1'b0;
		end else if (next_state == ST_LOCKOUT) begin
			next_ctrl.refresh_mode = 1'b1; // [R16]
		end
		next_ctrl.sram_oe = next_settings[`SRAM_EN_BIT]; // [R5]
		next_ctrl.dram_oe = next_settings[`DRAM_BACKUP_HI:`DRAM_BACKUP_LO]
			!= `DRAM_BACKUP_OFF; // [R5]
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl <= '{batt_rst_n: 1'b0, prime_rst_n: 1'b0,
				core_rst_n: 1'b0, line_oe: 1'b1, irq: 1'b0,
				lockout: 1'b1, refresh_mode: 1'b0, sram_oe: 1'b0,
				dram_oe: 1'b0};
		end else begin
			ctrl <= next_ctrl;
		end
	end

	// ports taken straight from the flops, except the line output tied low
	assign battery_domain_rst_n = ctrl.batt_rst_n;
	assign prime_rst_n = ctrl.prime_rst_n;
	assign internal_core_rst_n = ctrl.core_rst_n;
	assign ext_sys_rst_line_out = 1'b0; // line is only ever pulled low
	assign ext_sys_rst_line_oe = ctrl.line_oe;
	assign power_fail_interrupt = ctrl.irq;
	assign cpu_lockout = ctrl.lockout;
	assign battery_refresh_mode = ctrl.refresh_mode;
	assign sram_cs_oe = ctrl.sram_oe;
	assign dram_strobe_oe = ctrl.dram_oe;
	assign battery_settings_register = settings;

endmodule

// ==== rtl/pin_sync2.sv ====
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync2 #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end

endmodule

// ==== rtl/reset_seq_map.svh ====
// constants for the battery and prime power reset sequencer
// Function
// R1 - separate battery-domain reset and prime-power reset outputs
// R2 - third reset from watchdog expiry or system reset line pulled low
// R3 - battery reset input low resets battery domain, forces prime reset
// R4 - battery reset clears settings register and asserts CPU lockout
// R5 - backup disabled: SRAM select and DRAM strobes released to high-Z
// R6 - prime reset whenever power-fail input low with prime power applied; code holds it off in ST_ARM until lockout
// R7 - power-fail rising starts delay one, one or two reset clocks
// R8 - reset clock is RTC oscillator divided by 4096
// R9 - delay two: six peripheral clocks plus auxiliary clock retiming
// R10 - after delay two, retime to auxiliary clock, release line to high-Z
// R11 - core reset releases about eight peripheral clocks after line release
// R12 - lockout removed on next RTC rising edge after core reset release
// R13 - falling power-fail input with supply good raises interrupt
// R14 - CPU interrupt handler finally writes lockout-enable to arm lockout
// R15 - lock at once if DRAM backup off, else wait for refresh idle
// R16 - lockout: battery refresh mode, battery reset, inactive until power-on
// R17 - hardware time-out forces lockout if software never arms it
// R18 - settings bit 12 set when battery reset input detected
// R19 - settings bit 11 set on lockout enable, time-out or software
// R20 - each status flag cleared only by writing one to it
// R21 - without battery use, tie battery reset input to power-fail input
// R22 - system reset line leaves battery registers and refresh untouched
// R23 - power-fail and battery reset inputs synchronised before sequencing
`ifndef RESET_SEQ_MAP_SVH
`define RESET_SEQ_MAP_SVH

`define SETTINGS_RST_VAL 16'h0000
`define BATT_FLAG_BIT 12
`define LOCK_FLAG_BIT 11
`define SRAM_EN_BIT 10
`define DRAM_BACKUP_HI 7
`define DRAM_BACKUP_LO 6
`define SETTINGS_USED_MASK 16'h3fff
`define DRAM_BACKUP_OFF 2'h0

`define RTC_OSC_HZ 32768
`define RESET_CLK_DIV 4096
`define RESET_CLK_DIV_MAX 12'hfff
`define FIRST_POWERUP_DELAY_FALLS 3'h2
`define SECOND_POWERUP_DELAY_PERIODS 4'h6
`define CORE_WAIT_PERIODS 4'h8
`define LOCK_TIMEOUT_TICKS 4'h8

`endif

// ==== rtl/reset_seq_pkg.sv ====
// types shared by the reset sequencer files
package reset_seq_pkg;

	// synchronised pin inputs, sampled together
	typedef struct packed {
		logic battery_rst_n;
		logic power_fail_n;
		logic core_ok;
		logic rtc_osc;
		logic periph_clk;
		logic aux_clk;
		logic sys_line_n;
	} pin_in_t;

	// sequencer states, one-hot
	typedef enum logic [9:0] {
		ST_BATT_RST  = 10'h001,
		ST_OFF       = 10'h002,
		ST_FIRST_POWERUP_DELAY      = 10'h004,
		ST_SECOND_POWERUP_DELAY      = 10'h008,
		ST_LINE_SYNC = 10'h010,
		ST_CORE_WAIT = 10'h020,
		ST_UNLOCK    = 10'h040,
		ST_RUN       = 10'h080,
		ST_ARM       = 10'h100,
		ST_LOCKOUT   = 10'h200
	} seq_state_t;

	// registered control outputs
	typedef struct packed {
		logic batt_rst_n;
		logic prime_rst_n;
		logic core_rst_n;
		logic line_oe;
		logic irq;
		logic lockout;
		logic refresh_mode;
		logic sram_oe;
		logic dram_oe;
	} ctrl_out_t;

endpackage

// ==== tb/far_side_model.sv ====
// far side: slow clocks and the cpu power-fail handler
`timescale 1ns/1ps
module far_side_model (
	input wire logic sys_clk,
	input wire logic power_fail_interrupt,
	input wire logic handler_on,
	output logic rtc_osc_out,
	output logic peripheral_clock,
	output logic auxiliary_clock,
	output logic lockout_enable_write
);
	logic [3:0] div = 4'h0;
	int busy = 0;
	assign rtc_osc_out = div[0];
	assign peripheral_clock = div[1];
	assign auxiliary_clock = div[3];
	initial lockout_enable_write = 1'b0;
	// fast rtc keeps the 4096 divider inside the run budget
	always @(posedge sys_clk) begin
		#1 div = div + 4'h1;
	end
	// handler cleans up first, arms the lockout as its last act
	always @(posedge sys_clk) begin
		#1 busy = (power_fail_interrupt && handler_on) ? busy + 1 : 0;
		lockout_enable_write = (busy == 20);
	end
endmodule

// ==== tb/reset_seq_asserts.sv ====
// port checker for the battery and prime reset sequencer
`timescale 1ns/1ps
module reset_seq_asserts (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic battery_rst_in_n,
	input wire logic power_fail_in_n,
	input wire logic settings_write,
	input wire logic [15:0] settings_wdata,
	input wire logic lockout_enable_write,
	input wire logic battery_domain_rst_n,
	input wire logic prime_rst_n,
	input wire logic internal_core_rst_n,
	input wire logic ext_sys_rst_line_oe,
	input wire logic power_fail_interrupt,
	input wire logic cpu_lockout,
	input wire logic battery_refresh_mode,
	input wire logic sram_cs_oe,
	input wire logic dram_strobe_oe,
	input wire logic [15:0] battery_settings_register
);
	logic [15:0] cfg;
	assign cfg = battery_settings_register;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	chk_batt_hold: assert property (!battery_rst_in_n [*6] |->
		cpu_lockout && !battery_domain_rst_n && !prime_rst_n && cfg[12] &&
		!sram_cs_oe) else $error("battery reset outputs wrong");
	chk_pf_prime: assert property (!power_fail_in_n [*6] |->
		!prime_rst_n || power_fail_interrupt) else $error("prime reset missing");
	chk_oe_follow: assert property (sram_cs_oe == cfg[10] &&
		dram_strobe_oe == (|cfg[7:6])) else $error("backup enables mismatch");
	chk_core_after_line: assert property ($rose(internal_core_rst_n) |->
		!ext_sys_rst_line_oe && !$past(ext_sys_rst_line_oe, 12))
		else $error("core reset left too early");
	chk_unlock_late: assert property ($fell(cpu_lockout) |->
		internal_core_rst_n && $past(internal_core_rst_n))
		else $error("lockout removed before core reset");
	// refresh runs on through the next power-up, so resets may lift early
	chk_lockout_all: assert property (battery_refresh_mode |->
		cpu_lockout && !power_fail_interrupt && (battery_domain_rst_n ||
		(!prime_rst_n && ext_sys_rst_line_oe)))
		else $error("lockout outputs wrong");
	chk_irq_run: assert property ($rose(power_fail_interrupt) |->
		internal_core_rst_n && !cpu_lockout) else $error("irq outside run");
	chk_core_line: assert property ($fell(internal_core_rst_n) |->
		ext_sys_rst_line_oe) else $error("line not driven with core reset");
	chk_lock_flag: assert property ($rose(battery_refresh_mode) |->
		cfg[11]) else $error("lock flag not set");
	chk_locked_write: assert property (cpu_lockout && settings_write &&
		battery_rst_in_n |=> $stable(cfg)) else $error("write while locked");
	chk_flag_clear: assert property (settings_write && !cpu_lockout &&
		settings_wdata[11] && !power_fail_interrupt && !lockout_enable_write
		|=> !cfg[11]) else $error("flag not cleared");
endmodule
bind battery_prime_reset_sequencer reset_seq_asserts i_reset_seq_asserts (
	.sys_clk, .rst_n, .battery_rst_in_n, .power_fail_in_n, .settings_write,
	.settings_wdata, .lockout_enable_write, .battery_domain_rst_n,
	.prime_rst_n, .internal_core_rst_n, .ext_sys_rst_line_oe,
	.power_fail_interrupt, .cpu_lockout, .battery_refresh_mode, .sram_cs_oe,
	.dram_strobe_oe, .battery_settings_register);

// ==== tb/tb.sv ====
// self-checking bench for the battery and prime reset sequencer
`timescale 1ns/1ps
module tb;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic battery_rst_in_n, power_fail_in_n, core_supply_ok, watchdog_expired;
	logic settings_write, dram_refresh_busy, ext_pull, handler_on;
	logic [15:0] settings_wdata, battery_settings_register, e, w;
	logic rtc_osc_out, peripheral_clock, auxiliary_clock, lockout_enable_write;
	logic battery_domain_rst_n, prime_rst_n, internal_core_rst_n;
	logic ext_sys_rst_line_out, ext_sys_rst_line_oe, ext_sys_rst_line_in;
	logic power_fail_interrupt, cpu_lockout, battery_refresh_mode;
	logic sram_cs_oe, dram_strobe_oe;
	int failures = 0;
	int comparisons = 0;
	int seed = 32'hf2809033;
	int n;
	// shared line: pulled up unless someone pulls it low
	assign ext_sys_rst_line_in = !(ext_sys_rst_line_oe || ext_pull);
	always #10 sys_clk = ~sys_clk;
	battery_prime_reset_sequencer i_battery_prime_reset_sequencer (.sys_clk,
		.rst_n, .battery_rst_in_n, .power_fail_in_n, .core_supply_ok,
		.rtc_osc_out, .peripheral_clock, .auxiliary_clock, .ext_sys_rst_line_in,
		.watchdog_expired, .lockout_enable_write, .settings_write,
		.settings_wdata, .dram_refresh_busy, .battery_domain_rst_n, .prime_rst_n,
		.internal_core_rst_n, .ext_sys_rst_line_out, .ext_sys_rst_line_oe,
		.power_fail_interrupt, .cpu_lockout, .battery_refresh_mode, .sram_cs_oe,
		.dram_strobe_oe, .battery_settings_register);
	far_side_model i_far_side_model (.sys_clk, .power_fail_interrupt,
		.handler_on, .rtc_osc_out, .peripheral_clock, .auxiliary_clock,
		.lockout_enable_write);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// flags clear on one, other bits take the write, top bits read zero
	function automatic logic [15:0] nxt(input logic [15:0] c,
		input logic [15:0] d);
		return {2'h0, d[13], c[12] & ~d[12], c[11] & ~d[11], d[10:0]};
	endfunction
	function automatic logic pick(input int s);
		case (s)
			0: return battery_domain_rst_n;
			1: return !ext_sys_rst_line_oe;
			2: return internal_core_rst_n;
			3: return !cpu_lockout;
			4: return power_fail_interrupt;
			5: return battery_refresh_mode;
			default: return !internal_core_rst_n;
		endcase
	endfunction
	// sampled on the falling edge, clear of the register updates
	task automatic wait_on(input int sel, output int cnt);
		cnt = 0;
		while (pick(sel) !== 1'b1 && cnt < 40000) begin
			@(negedge sys_clk);
			cnt++;
		end
		if (cnt >= 40000) begin
			failures++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, pick(sel), 1'b1);
		end
	endtask
	task automatic wr(input logic [15:0] d);
		@(posedge sys_clk);
		#1 settings_write = 1'b1;
		settings_wdata = d;
		@(posedge sys_clk);
		#1 settings_write = 1'b0;
		@(negedge sys_clk);
	endtask
	task automatic final_report;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial begin
		#1200000;
		failures++;
		final_report;
	end
	initial begin
		{battery_rst_in_n, power_fail_in_n, watchdog_expired} = 3'h0;
		{settings_write, dram_refresh_busy, ext_pull, handler_on} = 4'h0;
		core_supply_ok = 1'b1;
		settings_wdata = 16'h0000;
		repeat (2) @(posedge sys_clk);
		#1 rst_n = 1'b1;
		repeat (8) @(negedge sys_clk);
		chk(battery_settings_register, 16'h1000);
		chk({cpu_lockout, prime_rst_n, sram_cs_oe}, 16'h4);
		@(posedge sys_clk);
		#1 battery_rst_in_n = 1'b1;
		repeat (20) @(negedge sys_clk);
		chk(prime_rst_n, 16'h0);
		@(posedge sys_clk);
		#1 power_fail_in_n = 1'b1;
		wait_on(0, n);
		chk(n >= 8190 && n <= 16500, 16'h1);
		chk({prime_rst_n, internal_core_rst_n, ext_sys_rst_line_oe}, 16'h5);
		wait_on(1, n);
		chk(n >= 20 && n <= 70, 16'h1);
		chk(ext_sys_rst_line_out, 16'h0);
		wait_on(2, n);
		chk(n >= 28 && n <= 70, 16'h1);
		wait_on(3, n);
		chk(n <= 8, 16'h1);
		e = 16'h1000;
		for (int i = 0; i < 10; i++) begin
			w = (i == 0) ? 16'hefff : (i == 1) ? 16'h1000 : 16'($random(seed));
			wr(w);
			e = nxt(e, w);
			chk(battery_settings_register, e);
			chk({sram_cs_oe, dram_strobe_oe}, {e[10], |e[7:6]});
		end
		for (int k = 0; k < 2; k++) begin
			@(posedge sys_clk);
			#1 {watchdog_expired, ext_pull} = (k == 0) ? 2'h2 : 2'h1;
			wait_on(6, n);
			chk(n <= 8, 16'h1);
			chk({ext_sys_rst_line_oe, battery_domain_rst_n}, 16'h3);
			chk(battery_settings_register, e);
			@(posedge sys_clk);
			#1 {watchdog_expired, ext_pull} = 2'h0;
			wait_on(2, n);
			wait_on(3, n);
		end
		wr(16'h0040);
		e = nxt(e, 16'h0040);
		@(posedge sys_clk);
		#1 {power_fail_in_n, dram_refresh_busy, handler_on} = 3'h3;
		wait_on(4, n);
		chk(n <= 8, 16'h1);
		repeat (60) @(negedge sys_clk);
		chk({battery_refresh_mode, power_fail_interrupt}, 16'h1);
		chk(battery_settings_register[11], 16'h1);
		@(posedge sys_clk);
		#1 dram_refresh_busy = 1'b0;
		wait_on(5, n);
		chk(n <= 8, 16'h1);
		chk({prime_rst_n, battery_domain_rst_n, cpu_lockout}, 16'h1);
		wr(16'h0000);
		chk(battery_settings_register, e | 16'h0800);
		// supply loss ends lockout, battery side keeps its state
		@(posedge sys_clk);
		#1 core_supply_ok = 1'b0;
		repeat (8) @(negedge sys_clk);
		chk({battery_refresh_mode, prime_rst_n, cpu_lockout}, 16'h5);
		@(posedge sys_clk);
		#1 {core_supply_ok, power_fail_in_n} = 2'h3;
		wait_on(3, n);
		chk({battery_refresh_mode, internal_core_rst_n}, 16'h1);
		chk(battery_settings_register, e | 16'h0800);
		// backup off: an armed lockout must not wait for refresh
		e = nxt(e | 16'h0800, 16'h0000);
		wr(16'h0000);
		chk({sram_cs_oe, dram_strobe_oe}, 16'h0);
		@(posedge sys_clk);
		#1 power_fail_in_n = 1'b0;
		dram_refresh_busy = 1'b1;
		wait_on(5, n);
		chk(n >= 20 && n <= 40, 16'h1);
		chk(battery_settings_register, e);
		final_report;
	end
endmodule
